/* File: rtl/ufl_pkg.sv */
package ufl_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_PULLUP = 8'h04;
  localparam logic [7:0] ADDR_FORCE_VAL = 8'h08;
  localparam logic [7:0] ADDR_TASK = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_DEV_ADDR = 8'h14;
  localparam logic [7:0] ADDR_EP_IN_EN = 8'h18;
  localparam logic [7:0] ADDR_EP_OUT_EN = 8'h1C;
  localparam logic [7:0] ADDR_EVENTS = 8'h20;
  localparam logic [7:0] ADDR_CAPS = 8'h24;
  // Task register bit positions
  localparam int TASK_FORCE_BIT = 0;
  localparam int TASK_RELEASE_BIT = 1;
  // Event register bit positions (write one to clear)
  localparam int EV_BUS_RESET_BIT = 0;
  // Reset values
  localparam logic ENABLE_RST = 1'b0;
  localparam logic PULLUP_RST = 1'b0;
  localparam logic [6:0] DEV_ADDR_RST = 7'h00;
  localparam logic [7:0] EP_EN_RST = 8'h01;
  // Endpoint capabilities
  localparam int BULK_EP_PER_DIR = 7;
  localparam int BULK_BUF_BYTES = 64;
  localparam int ISO_BUF_BYTES = 1023;
  localparam int ISO_BUF_COUNT = 2;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int DETRST_NS = 2500;
  localparam int DETRST_CYC = (DETRST_NS * CLK_MHZ + 999) / 1000;
  localparam int SHUTDOWN_NS = 100;
  localparam int SHUTDOWN_CYC = (SHUTDOWN_NS * CLK_MHZ + 999) / 1000;
  localparam int PHY_RDY_NS = 1000;
  localparam int PHY_RDY_CYC = (PHY_RDY_NS * CLK_MHZ + 999) / 1000;
  localparam int PULL_IDLE_CYC = 16;
  // Bus line states
  typedef enum logic [2:0] {
    UFL_LS_SE0, UFL_LS_J, UFL_LS_K, UFL_LS_SE1
  } ufl_line_e;
  // Force values
  localparam logic [1:0] FORCE_J = 2'h1;
  localparam logic [1:0] FORCE_K = 2'h2;
endpackage

/* File: rtl/ufl_line_if.sv */
`timescale 1ns/1ns
interface ufl_line_if;
  logic dp;
  logic dm;
  logic se0;
  logic jst;
  logic kst;
  logic se1;
  modport ctl (input se0, input jst, input kst, input se1);
  modport det (input dp, input dm, output se0, output jst, output kst,
    output se1);
endinterface

/* File: rtl/ufl_line_state.sv */
`timescale 1ns/1ns
module ufl_line_state (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Line state
  ufl_line_if.det line
);
  logic [1:0] pair_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pair_reg <= 2'h0;
    end else begin
      pair_reg <= {line.dp, line.dm};
    end
  end
  assign line.jst = (pair_reg == 2'h2); // [RQ1]
  assign line.kst = (pair_reg == 2'h1); // [RQ2]
  assign line.se0 = (pair_reg == 2'h0); // [RQ3]
  assign line.se1 = (pair_reg == 2'h3); // [RQ3]
endmodule

/* File: rtl/ufl_link_ctl.sv */
`timescale 1ns/1ns
// What this block and its software must do
// (RQ1) D+ high, D- low is J
// (RQ2) D+ low, D- high is K
// (RQ3) Both low SE0, both high SE1
// (RQ4) Pins and pull-up need VBUS and enable
// (RQ5) Enable setting powers the transceiver
// (RQ6) Software enables after VBUS, pull-up after ready
// (RQ7) Software waits transfer ends before disabling
// (RQ8) Enable reads enabled until shutdown completes
// (RQ9) Pull-up control gates connection and events
// (RQ10) Pull-up disconnected after chip reset
// (RQ11) No bus reset while pull-up off
// (RQ12) Software connects pull-up after enabling
// (RQ13) Hardware adjusts pull-up value by activity
// (RQ14) Force task drives lines, release stops
// (RQ15) Force value captured at task trigger
// (RQ16) Long SE0 raises bus reset event only
// (RQ17) Bus reset disables data endpoints, address 0
// (RQ18) Ignore traffic until first bus reset
// (RQ19) Responsive within recovery time after reset
// (RQ20) Full speed only, no high-speed chirp
// (RQ21) Control, seven bulk, one iso each way
// (RQ22) Bulk 64-byte, iso up to 1023 bytes
// (RQ23) Iso endpoints double buffered
// (RQ24) Reset timer restarts on non-SE0 sample
module ufl_link_ctl #(
  parameter int DETRST_CYCLES = ufl_pkg::DETRST_CYC,
  parameter int SHUTDOWN_CYCLES = ufl_pkg::SHUTDOWN_CYC,
  parameter int PHY_RDY_CYCLES = ufl_pkg::PHY_RDY_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Supply and bus lines
  input wire logic i_vbus_valid,
  input wire logic i_dp,
  input wire logic i_dm,
  output logic o_dp,
  output logic o_dp_oe,
  output logic o_dm,
  output logic o_dm_oe,
  // Transceiver power and pull-up
  output logic o_phy_power,
  output logic o_pullup_on,
  output logic o_pullup_strong,
  // Status to the protocol engine
  output logic o_bus_reset_event,
  output logic o_phy_power_ready_event,
  output logic o_traffic_allowed,
  output logic o_full_speed_only
);
  // ****************************************
  // Line state
  // ****************************************
  ufl_line_if line ();
  assign line.dp = i_dp;
  assign line.dm = i_dm;
  ufl_line_state u_line (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .line(line)
  );

  // ****************************************
  // Register decode
  // ****************************************
  logic wr_enable;
  logic wr_pullup;
  logic wr_force_val;
  logic wr_task;
  logic wr_events;
  logic wr_ep_in;
  logic wr_ep_out;
  assign wr_enable = i_wr && (i_addr == ufl_pkg::ADDR_ENABLE);
  assign wr_pullup = i_wr && (i_addr == ufl_pkg::ADDR_PULLUP);
  assign wr_force_val = i_wr && (i_addr == ufl_pkg::ADDR_FORCE_VAL);
  assign wr_task = i_wr && (i_addr == ufl_pkg::ADDR_TASK);
  assign wr_events = i_wr && (i_addr == ufl_pkg::ADDR_EVENTS);
  assign wr_ep_in = i_wr && (i_addr == ufl_pkg::ADDR_EP_IN_EN);
  assign wr_ep_out = i_wr && (i_addr == ufl_pkg::ADDR_EP_OUT_EN);

  logic force_trig;
  logic release_trig;
  assign force_trig = wr_task && i_wdata[ufl_pkg::TASK_FORCE_BIT];
  assign release_trig = wr_task && i_wdata[ufl_pkg::TASK_RELEASE_BIT];

  // ****************************************
  // Enable and shutdown
  // ****************************************
  logic enable_reg;
  logic active_reg;
  logic [15:0] shut_cnt_reg;
  logic [15:0] shut_cnt_next;
  logic [15:0] rdy_cnt_reg;
  logic phy_rdy_reg;
  logic shut_done;
  assign shut_done = (shut_cnt_reg == 16'h0000);
  assign shut_cnt_next = (active_reg && !enable_reg && !shut_done) ?
    shut_cnt_reg - 16'h0001 : shut_cnt_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_reg <= ufl_pkg::ENABLE_RST;
      active_reg <= 1'b0;
      shut_cnt_reg <= 16'h0000;
    end else begin
      if (wr_enable) begin
        enable_reg <= i_wdata[0];
      end
      shut_cnt_reg <= shut_cnt_next;
      if (enable_reg) begin
        active_reg <= 1'b1;
        shut_cnt_reg <= 16'(SHUTDOWN_CYCLES);
      end else if (shut_done) begin
        active_reg <= 1'b0; // [RQ8]
      end
    end
  end

  // Power ready after regulator settle time
  logic phy_on;
  assign phy_on = active_reg && i_vbus_valid;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdy_cnt_reg <= 16'h0000;
      phy_rdy_reg <= 1'b0;
    end else if (!enable_reg) begin
      rdy_cnt_reg <= 16'h0000;
      phy_rdy_reg <= 1'b0;
    end else if (!phy_rdy_reg) begin
      rdy_cnt_reg <= rdy_cnt_reg + 16'h0001;
      phy_rdy_reg <= (rdy_cnt_reg == 16'(PHY_RDY_CYCLES - 1));
    end
  end

  // ****************************************
  // Pull-up
  // ****************************************
  logic pullup_reg;
  logic pull_on;
  logic [4:0] idle_cnt_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pullup_reg <= ufl_pkg::PULLUP_RST; // [RQ10]
    end else if (wr_pullup) begin
      pullup_reg <= i_wdata[0]; // [RQ9]
    end
  end
  // Pull-up only on with supply, enable and a powered phy
  assign pull_on = pullup_reg && phy_on && enable_reg; // [RQ4]

  // Weaker pull-up while bus idles, strong on activity
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_cnt_reg <= 5'h00;
    end else if (!line.jst) begin
      idle_cnt_reg <= 5'h00;
    end else if (idle_cnt_reg != 5'(ufl_pkg::PULL_IDLE_CYC)) begin
      idle_cnt_reg <= idle_cnt_reg + 5'h01;
    end
  end

  // ****************************************
  // Line force
  // ****************************************
  logic [1:0] force_val_reg;
  logic [1:0] force_cap_reg;
  logic forcing_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      force_val_reg <= 2'h0;
      force_cap_reg <= 2'h0;
      forcing_reg <= 1'b0;
    end else begin
      if (wr_force_val) begin
        force_val_reg <= i_wdata[1:0];
      end
      if (force_trig) begin
        force_cap_reg <= force_val_reg; // [RQ15]
        forcing_reg <= 1'b1; // [RQ14]
      end else if (release_trig || !phy_on) begin
        forcing_reg <= 1'b0; // [RQ14]
      end
    end
  end

  // ****************************************
  // Bus reset detection
  // ****************************************
  logic [15:0] se0_cnt_reg;
  logic [15:0] se0_cnt_next;
  logic det_hit;
  logic seen_reset_reg;
  logic ev_reset_reg;
  logic [6:0] dev_addr_reg;
  logic [7:0] ep_in_reg;
  logic [7:0] ep_out_reg;
  logic count_ok;
  // Only a connected, non-driving device listens for reset
  assign count_ok = pull_on && line.se0 && !forcing_reg; // [RQ11]
  assign se0_cnt_next = !count_ok ? 16'h0000 : // [RQ24]
    (det_hit ? se0_cnt_reg : se0_cnt_reg + 16'h0001);
  assign det_hit = (se0_cnt_reg == 16'(DETRST_CYCLES));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      se0_cnt_reg <= 16'h0000;
    end else begin
      se0_cnt_reg <= se0_cnt_next; // [RQ16]
    end
  end

  logic reset_pulse;
  assign reset_pulse = count_ok &&
    (se0_cnt_reg == 16'(DETRST_CYCLES - 1)); // [RQ16]

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_reset_reg <= 1'b0;
      ev_reset_reg <= 1'b0;
      dev_addr_reg <= ufl_pkg::DEV_ADDR_RST;
      ep_in_reg <= ufl_pkg::EP_EN_RST;
      ep_out_reg <= ufl_pkg::EP_EN_RST;
    end else begin
      if (!pull_on) begin
        seen_reset_reg <= 1'b0; // [RQ18]
      end else if (reset_pulse) begin
        seen_reset_reg <= 1'b1; // [RQ18]
      end
      // Set beats a simultaneous clear
      if (reset_pulse) begin
        ev_reset_reg <= 1'b1;
      end else if (wr_events && i_wdata[ufl_pkg::EV_BUS_RESET_BIT]) begin
        ev_reset_reg <= 1'b0;
      end
      if (reset_pulse) begin
        dev_addr_reg <= ufl_pkg::DEV_ADDR_RST; // [RQ17]
        ep_in_reg <= ufl_pkg::EP_EN_RST; // [RQ17]
        ep_out_reg <= ufl_pkg::EP_EN_RST; // [RQ17]
      end else begin
        if (i_wr && i_addr == ufl_pkg::ADDR_DEV_ADDR) begin
          dev_addr_reg <= i_wdata[6:0];
        end
        if (wr_ep_in) begin
          ep_in_reg <= i_wdata[7:0];
        end
        if (wr_ep_out) begin
          ep_out_reg <= i_wdata[7:0];
        end
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic phy_rdy_d_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_phy_power <= 1'b0;
      o_pullup_on <= 1'b0;
      o_pullup_strong <= 1'b0;
      o_dp <= 1'b0;
      o_dm <= 1'b0;
      o_dp_oe <= 1'b0;
      o_dm_oe <= 1'b0;
      o_bus_reset_event <= 1'b0;
      o_phy_power_ready_event <= 1'b0;
      phy_rdy_d_reg <= 1'b0;
      o_traffic_allowed <= 1'b0;
      o_full_speed_only <= 1'b0;
    end else begin
      o_phy_power <= enable_reg; // [RQ5]
      o_pullup_on <= pull_on; // [RQ4] [RQ9]
      // Strong pull-up once bus leaves idle
      o_pullup_strong <= pull_on &&
        (idle_cnt_reg != 5'(ufl_pkg::PULL_IDLE_CYC)); // [RQ13]
      o_dp <= (force_cap_reg == ufl_pkg::FORCE_J); // [RQ14]
      o_dm <= (force_cap_reg == ufl_pkg::FORCE_K); // [RQ14]
      // Pins stay quiet once enable drops, even during shutdown
      o_dp_oe <= forcing_reg && phy_on && enable_reg; // [RQ4]
      o_dm_oe <= forcing_reg && phy_on && enable_reg; // [RQ4]
      o_bus_reset_event <= reset_pulse; // [RQ16]
      phy_rdy_d_reg <= phy_rdy_reg;
      o_phy_power_ready_event <= phy_rdy_reg && !phy_rdy_d_reg;
      // No chirp answer; traffic only after first reset
      o_traffic_allowed <= pull_on && seen_reset_reg; // [RQ18] [RQ19]
      o_full_speed_only <= 1'b1; // [RQ20]
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  logic [31:0] rd_mux;
  logic [31:0] caps;
  assign caps = {8'(ufl_pkg::ISO_BUF_COUNT), 10'(ufl_pkg::ISO_BUF_BYTES),
    7'(ufl_pkg::BULK_BUF_BYTES), 7'(ufl_pkg::BULK_EP_PER_DIR)}; // [RQ21]
  always_comb begin
    unique case (i_addr)
      ufl_pkg::ADDR_ENABLE: rd_mux = {31'h0, active_reg}; // [RQ8]
      ufl_pkg::ADDR_PULLUP: rd_mux = {31'h0, pullup_reg};
      ufl_pkg::ADDR_FORCE_VAL: rd_mux = {30'h0, force_val_reg};
      ufl_pkg::ADDR_STATUS: rd_mux = {26'h0, seen_reset_reg, forcing_reg,
        line.se1, line.kst, line.jst, line.se0};
      ufl_pkg::ADDR_DEV_ADDR: rd_mux = {25'h0, dev_addr_reg};
      ufl_pkg::ADDR_EP_IN_EN: rd_mux = {24'h0, ep_in_reg};
      ufl_pkg::ADDR_EP_OUT_EN: rd_mux = {24'h0, ep_out_reg};
      ufl_pkg::ADDR_EVENTS: rd_mux = {31'h0, ev_reset_reg};
      ufl_pkg::ADDR_CAPS: rd_mux = caps; // [RQ22] [RQ23]
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  no_rst_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !pull_on |=> !o_bus_reset_event) else $error("reset while off"); // [RQ11]
  rst_clears_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    reset_pulse |=> dev_addr_reg == 7'h00 && ep_in_reg == 8'h01)
    else $error("bus reset left address"); // [RQ17]
  se0_restart_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !line.se0 |=> se0_cnt_reg == 16'h0000)
    else $error("timer not restarted"); // [RQ24]
  power_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> o_phy_power == $past(enable_reg))
    else $error("power not following"); // [RQ5]
  pull_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_vbus_valid |=> !o_pullup_on)
    else $error("pull-up without supply"); // [RQ4]
  enable_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(enable_reg) |-> active_reg)
    else $error("enable dropped early"); // [RQ8]
  force_cap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    force_trig |=> forcing_reg && force_cap_reg == $past(force_val_reg))
    else $error("force value not taken"); // [RQ15]
  quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(pull_on) |=> !o_traffic_allowed [*2])
    else $error("traffic before reset"); // [RQ18]
endmodule

/* File: verif/ufl_host_model.sv */
`timescale 1ns/1ns
// ************************************
// Host end of the D+/D- pair
// ************************************
module ufl_host_model (
  // Host command: 0 release, 1 SE0, 2 J, 3 K, 4 SE1
  input wire logic [2:0] i_mode,
  // Device side of the pins
  input wire logic i_pullup_on,
  input wire logic i_dp,
  input wire logic i_dp_oe,
  input wire logic i_dm,
  input wire logic i_dm_oe,
  // Resolved wire levels
  output logic o_dp,
  output logic o_dm
);
  logic host_drv;
  logic [1:0] host_lines;
  assign host_drv = (i_mode != 3'h0);
  assign host_lines = (i_mode == 3'h2) ? 2'h2 : (i_mode == 3'h3) ? 2'h1 :
    (i_mode == 3'h4) ? 2'h3 : 2'h0;
  // Device drive wins; released bus falls to pull-up J or pull-down SE0
  assign o_dp = i_dp_oe ? i_dp :
    host_drv ? host_lines[1] : i_pullup_on;
  assign o_dm = i_dm_oe ? i_dm :
    (host_drv & host_lines[0]);
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  localparam int N = 8;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_vbus_valid = 1'b0;
  logic [2:0] host_mode = 3'h0;
  logic [31:0] o_rdata;
  logic dp, dm, o_dp, o_dp_oe, o_dm, o_dm_oe, o_phy_power, o_pullup_on;
  logic o_pullup_strong, o_bus_reset_event, o_phy_power_ready_event;
  logic o_traffic_allowed, o_full_speed_only;
  logic [31:0] seed;
  logic [3:0] q[$];
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;

  always #2 i_clk = ~i_clk;

  ufl_link_ctl #(.DETRST_CYCLES(N), .SHUTDOWN_CYCLES(ufl_pkg::SHUTDOWN_CYC),
    .PHY_RDY_CYCLES(4)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_vbus_valid(i_vbus_valid), .i_dp(dp), .i_dm(dm),
    .o_dp(o_dp), .o_dp_oe(o_dp_oe), .o_dm(o_dm), .o_dm_oe(o_dm_oe),
    .o_phy_power(o_phy_power), .o_pullup_on(o_pullup_on),
    .o_pullup_strong(o_pullup_strong), .o_bus_reset_event(o_bus_reset_event),
    .o_phy_power_ready_event(o_phy_power_ready_event),
    .o_traffic_allowed(o_traffic_allowed),
    .o_full_speed_only(o_full_speed_only));

  ufl_host_model host (.i_mode(host_mode), .i_pullup_on(o_pullup_on),
    .i_dp(o_dp), .i_dp_oe(o_dp_oe), .i_dm(o_dm), .i_dm_oe(o_dm_oe),
    .o_dp(dp), .o_dm(dm));

  // ************************************
  // Shared tasks
  // ************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic final_report();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(nm, e, o_rdata);
  endtask

  task automatic hm(input logic [2:0] m);
    @(posedge i_clk);
    host_mode <= m;
  endtask

  // Counts bus reset pulses seen over n cycles
  task automatic count_ev(input int n, output int c);
    c = 0;
    repeat (n) begin
      tick(1);
      if (o_bus_reset_event === 1'b1) c++;
    end
  endtask

  // Hang guard, normal run is under 1500 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      final_report();
    end
  end

  // ************************************
  // Main sequence
  // ************************************
  initial begin
    int c;
    int k;
    logic [6:0] adr;
    logic [1:0] e;
    seed = 32'h0001287A;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    tick(1);
    chk("full_speed", 32'h1, o_full_speed_only);
    chk("pullup_on", 32'h0, o_pullup_on);
    rchk("pullup", ufl_pkg::ADDR_PULLUP, 32'h0);
    rchk("enable", ufl_pkg::ADDR_ENABLE, 32'h0);
    // Enable before supply, to see the pull-up held off
    wr(ufl_pkg::ADDR_ENABLE, 32'h1);
    k = 0;
    while (k < 20 && o_phy_power_ready_event !== 1'b1) begin
      tick(1);
      k++;
    end
    chk("phy_ready", 32'h1, o_phy_power_ready_event);
    chk("phy_power", 32'h1, o_phy_power);
    wr(ufl_pkg::ADDR_PULLUP, 32'h1);
    tick(3);
    chk("pullup_novbus", 32'h0, o_pullup_on);
    wr(ufl_pkg::ADDR_PULLUP, 32'h0);
    @(posedge i_clk);
    i_vbus_valid <= 1'b1;
    count_ev(3 * N, c);
    chk("ev_pullup_off", 32'h0, c);
    for (k = 0; k < 12; k++) begin
      seed = lfsr(seed);
      hm(3'(seed[1:0]) + 3'h1);
      q.push_back(4'(1 << seed[1:0]));
      tick(4);
      rchk("line_state", ufl_pkg::ADDR_STATUS,
        {28'h0, q.pop_front()});
    end
    hm(3'h0);
    rchk("events_off", ufl_pkg::ADDR_EVENTS, 32'h0);
    adr = seed[8:2] | 7'h01;
    wr(ufl_pkg::ADDR_DEV_ADDR, {25'h0, adr});
    wr(ufl_pkg::ADDR_EP_IN_EN, 32'hFF);
    wr(ufl_pkg::ADDR_EP_OUT_EN, 32'hFF);
    rchk("dev_addr", ufl_pkg::ADDR_DEV_ADDR, {25'h0, adr});
    wr(ufl_pkg::ADDR_PULLUP, 32'h1);
    tick(3);
    chk("pullup_on", 32'h1, o_pullup_on);
    chk("traffic_early", 32'h0, o_traffic_allowed);
    tick(20);
    chk("weak_idle", 32'h0, o_pullup_strong);
    // Short SE0 then J: count must restart
    hm(3'h1);
    tick(N - 2);
    hm(3'h0);
    count_ev(3 * N, c);
    chk("ev_short_se0", 32'h0, c);
    hm(3'h1);
    k = 0;
    while (k < 40 && o_bus_reset_event !== 1'b1) begin
      tick(1);
      k++;
    end
    chk("detect_len", 32'h1, 32'(k >= N && k <= N + 4));
    count_ev(20, c);
    chk("ev_once", 32'h0, c);
    chk("strong_busy", 32'h1, o_pullup_strong);
    chk("traffic", 32'h1, o_traffic_allowed);
    rchk("addr_clr", ufl_pkg::ADDR_DEV_ADDR, 32'h0);
    rchk("ep_in_clr", ufl_pkg::ADDR_EP_IN_EN, 32'h1);
    rchk("ep_out_clr", ufl_pkg::ADDR_EP_OUT_EN, 32'h1);
    rchk("enable_kept", ufl_pkg::ADDR_ENABLE, 32'h1);
    rchk("event_flag", ufl_pkg::ADDR_EVENTS, 32'h1);
    wr(ufl_pkg::ADDR_EVENTS, 32'h1);
    rchk("event_clr", ufl_pkg::ADDR_EVENTS, 32'h0);
    hm(3'h0);
    // Every force code; a later value write must not leak in
    for (k = 0; k < 4; k++) begin
      e = (k == 1) ? 2'h2 : (k == 2) ? 2'h1 : 2'h0;
      wr(ufl_pkg::ADDR_FORCE_VAL, 32'(k));
      wr(ufl_pkg::ADDR_TASK, 32'h1);
      wr(ufl_pkg::ADDR_FORCE_VAL, 32'(k ^ 3));
      tick(3);
      chk("force_pins", {28'h0, 2'h3, e},
        {o_dp_oe, o_dm_oe, o_dp, o_dm});
      chk("force_wire", {30'h0, e}, {dp, dm});
    end
    wr(ufl_pkg::ADDR_TASK, 32'h2);
    tick(3);
    chk("release", 32'h0, {o_dp_oe, o_dm_oe});
    wr(ufl_pkg::ADDR_PULLUP, 32'h0);
    tick(3);
    chk("pullup_off", 32'h0, {o_pullup_on, o_traffic_allowed});
    wr(ufl_pkg::ADDR_ENABLE, 32'h0);
    rchk("enable_busy", ufl_pkg::ADDR_ENABLE, 32'h1);
    tick(ufl_pkg::SHUTDOWN_CYC + 10);
    rchk("enable_done", ufl_pkg::ADDR_ENABLE, 32'h0);
    chk("phy_off", 32'h0, o_phy_power);
    final_report();
  end
endmodule
